//--- rtl/i2c_master_byte_transfer.sv
/*
 * Byte-oriented I2C master: write transactions from a transmit stream,
 * read transactions with up to five prefix bytes into a receive stream.
 * Assumes open-drain pins with external pull-ups and a single 100 MHz clock.
 */
// What this block does
// - data and clock pins chosen per transaction
// - each transaction addresses the caller's target
// - up to five prefix bytes; skipped slots unsent
// - first slot skipped means no write phase
// - prefix written directly ahead of the read
// - read exactly byte_count bytes, in order
// - every data unit is one byte
// - write sends byte_count bytes from transmit stream
// - only the low byte of transmit data sent
// - write reports 1 on slave address acknowledge, else 0
// - default rate about 350 kbit/s after reset
// - rate selectable 400, 100 or 50 kbit/s
`timescale 1ns/100ps
`default_nettype none
`include "i2c_master_defs.svh"

module i2c_master_byte_transfer
    import i2c_master_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire xfer_cmd_t cmd,
    input wire logic rate_set,
    input wire bus_rate_select_t bus_rate_select,
    input wire logic [`I2C_TX_W-1:0] tx_data,
    input wire logic tx_valid,
    output logic tx_ready,
    output logic [7:0] rx_data,
    output logic rx_valid,
    output logic done,
    output logic ack_result,
    input wire logic [`I2C_PIN_COUNT-1:0] pin_in,
    output logic [`I2C_PIN_COUNT-1:0] pin_out,
    output logic [`I2C_PIN_COUNT-1:0] pin_oe_n
);

    xfer_state_t state_q;
    bus_rate_select_t rate_q;
    logic [`I2C_QLEN_W-1:0] quarter_len;
    logic is_read_q;
    logic [`I2C_ADDR_W-1:0] addr_q;
    logic [`I2C_PIN_SEL_W-1:0] sda_sel_q;
    logic [`I2C_PIN_SEL_W-1:0] scl_sel_q;
    logic [`I2C_COUNT_W-1:0] remaining_q;
    logic [7:0] prefix_q [`I2C_PREFIX_SLOTS];
    logic [`I2C_PREFIX_SLOTS-1:0] pre_mask_q;
    logic [7:0] shift_q;
    logic [3:0] bit_cnt_q;
    logic addr_rd_q;
    logic load_q;
    logic issued_q;
    logic need_bit;
    logic bit_go;
    bit_op_t bit_op;
    logic bit_tx;
    logic bit_done;
    logic bit_rx;
    logic scl_low;
    logic sda_low;
    logic sda_in;
    logic [`I2C_PIN_COUNT-1:0] sync1_q;
    logic [`I2C_PIN_COUNT-1:0] sync2_q;
    logic [`I2C_PREFIX_SLOTS-1:0] start_mask;

    // rate register, 350k out of reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rate_q <= RATE_350K;
        end else if (rate_set) begin
            rate_q <= bus_rate_select;
        end
    end

    always_comb begin
        case (rate_q)
            RATE_400K: quarter_len = `I2C_QLEN_W'(`I2C_QUARTER_CYC(`I2C_BIT_NS_400K));
            RATE_100K: quarter_len = `I2C_QLEN_W'(`I2C_QUARTER_CYC(`I2C_BIT_NS_100K));
            RATE_50K: quarter_len = `I2C_QLEN_W'(`I2C_QUARTER_CYC(`I2C_BIT_NS_50K));
            default: quarter_len = `I2C_QLEN_W'(`I2C_QUARTER_CYC(`I2C_BIT_NS_350K));
        endcase
    end

    // a skipped first slot drops the whole write phase
    always_comb begin
        for (int i = 0; i < `I2C_PREFIX_SLOTS; i++) begin
            start_mask[i] = ~cmd.prefix_byte[i].skip & ~cmd.prefix_byte[0].skip;
        end
    end

    assign cmd_ready = (state_q == ST_IDLE);
    assign need_bit = (state_q != ST_IDLE) && (state_q != ST_DONE) &&
                      !((state_q == ST_WBYTE) && load_q);
    assign bit_go = need_bit && !issued_q;
    assign tx_ready = (state_q == ST_WBYTE) && load_q && !is_read_q && (remaining_q != '0);

    always_comb begin
        case (state_q)
            ST_START, ST_RESTART: bit_op = OP_START;
            ST_STOP: bit_op = OP_STOP;
            default: bit_op = OP_BIT;
        endcase
    end

    always_comb begin
        if (bit_cnt_q == `I2C_ACK_BIT) begin
            // master acks a read byte only while more are to come
            bit_tx = (state_q == ST_RBYTE) ? (remaining_q == `I2C_COUNT_W'(1)) : 1'b1;
        end else begin
            bit_tx = (state_q == ST_RBYTE) ? 1'b1 : shift_q[7];
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            issued_q <= 1'b0;
        end else if (bit_go) begin
            issued_q <= 1'b1;
        end else if (bit_done) begin
            issued_q <= 1'b0;
        end
    end

    // transaction sequencing
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            is_read_q <= 1'b0;
            addr_q <= '0;
            sda_sel_q <= '0;
            scl_sel_q <= '0;
            remaining_q <= '0;
            pre_mask_q <= '0;
            for (int i = 0; i < `I2C_PREFIX_SLOTS; i++) begin
                prefix_q[i] <= 8'h00;
            end
            shift_q <= 8'h00;
            bit_cnt_q <= 4'h0;
            addr_rd_q <= 1'b0;
            load_q <= 1'b0;
            rx_data <= 8'h00;
            rx_valid <= 1'b0;
            done <= 1'b0;
            ack_result <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            done <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (cmd_valid) begin
                        is_read_q <= cmd.is_read;
                        addr_q <= cmd.target_address;
                        sda_sel_q <= cmd.sda_pin;
                        scl_sel_q <= cmd.scl_pin;
                        remaining_q <= cmd.byte_count;
                        pre_mask_q <= start_mask;
                        for (int i = 0; i < `I2C_PREFIX_SLOTS; i++) begin
                            prefix_q[i] <= cmd.prefix_byte[i].value;
                        end
                        ack_result <= 1'b0;
                        state_q <= ST_START;
                    end
                end
                ST_START, ST_RESTART: begin
                    if (bit_done) begin
                        // read bit straight away when no write phase is due
                        addr_rd_q <= (state_q == ST_RESTART) ||
                                     (is_read_q && pre_mask_q == '0);
                        shift_q <= {addr_q, (state_q == ST_RESTART) ||
                                    (is_read_q && pre_mask_q == '0)};
                        bit_cnt_q <= 4'h0;
                        state_q <= ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (bit_done) begin
                        if (bit_cnt_q != `I2C_ACK_BIT) begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (bit_rx) begin
                            state_q <= ST_STOP;
                        end else begin
                            ack_result <= 1'b1;
                            bit_cnt_q <= 4'h0;
                            if (!addr_rd_q) begin
                                load_q <= 1'b1;
                                state_q <= ST_WBYTE;
                            end else if (remaining_q == '0) begin
                                state_q <= ST_STOP;
                            end else begin
                                state_q <= ST_RBYTE;
                            end
                        end
                    end
                end
                ST_WBYTE: begin
                    if (load_q) begin
                        bit_cnt_q <= 4'h0;
                        if (is_read_q) begin
                            // one slot per cycle; skipped ones just shift out
                            if (pre_mask_q == '0) begin
                                load_q <= 1'b0;
                                state_q <= ST_RESTART;
                            end else begin
                                if (pre_mask_q[0]) begin
                                    shift_q <= prefix_q[0];
                                    load_q <= 1'b0;
                                end
                                pre_mask_q <= pre_mask_q >> 1;
                                for (int i = 0; i < `I2C_PREFIX_SLOTS - 1; i++) begin
                                    prefix_q[i] <= prefix_q[i+1];
                                end
                            end
                        end else if (remaining_q == '0) begin
                            load_q <= 1'b0;
                            state_q <= ST_STOP;
                        end else if (tx_valid) begin
                            shift_q <= tx_data[7:0];
                            remaining_q <= remaining_q - `I2C_COUNT_W'(1);
                            load_q <= 1'b0;
                        end
                    end else if (bit_done) begin
                        if (bit_cnt_q != `I2C_ACK_BIT) begin
                            shift_q <= {shift_q[6:0], 1'b0};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else if (bit_rx) begin
                            // a refused data byte ends the transfer early
                            state_q <= ST_STOP;
                        end else begin
                            load_q <= 1'b1;
                        end
                    end
                end
                ST_RBYTE: begin
                    if (bit_done) begin
                        if (bit_cnt_q != `I2C_ACK_BIT) begin
                            shift_q <= {shift_q[6:0], bit_rx};
                            bit_cnt_q <= bit_cnt_q + 4'h1;
                        end else begin
                            rx_data <= shift_q;
                            rx_valid <= 1'b1;
                            remaining_q <= remaining_q - `I2C_COUNT_W'(1);
                            bit_cnt_q <= 4'h0;
                            if (remaining_q == `I2C_COUNT_W'(1)) begin
                                state_q <= ST_STOP;
                            end
                        end
                    end
                end
                ST_STOP: begin
                    if (bit_done) begin
                        done <= 1'b1;
                        state_q <= ST_DONE;
                    end
                end
                ST_DONE: begin
                    state_q <= ST_IDLE;
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    i2c_bit_engine i_i2c_bit_engine (
        .clk(clk),
        .sys_rst(sys_rst),
        .go(bit_go),
        .op(bit_op),
        .tx_bit(bit_tx),
        .quarter_len(quarter_len),
        .sda_in(sda_in),
        .done(bit_done),
        .rx_bit(bit_rx),
        .scl_low(scl_low),
        .sda_low(sda_low)
    );

    assign sda_in = sync2_q[sda_sel_q];

    // pins are open drain: only ever pulled low, released otherwise
    genvar g;
    generate
        for (g = 0; g < `I2C_PIN_COUNT; g++) begin : g_pin
            always_ff @(posedge clk or posedge sys_rst) begin
                if (sys_rst) begin
                    sync1_q[g] <= 1'b1;
                    sync2_q[g] <= 1'b1;
                    pin_oe_n[g] <= 1'b1;
                    pin_out[g] <= 1'b0;
                end else begin
                    sync1_q[g] <= pin_in[g];
                    sync2_q[g] <= sync1_q[g];
                    pin_oe_n[g] <= ~((sda_low && sda_sel_q == `I2C_PIN_SEL_W'(g)) ||
                                     (scl_low && scl_sel_q == `I2C_PIN_SEL_W'(g)));
                    pin_out[g] <= 1'b0;
                end
            end
        end
    endgenerate

endmodule

`default_nettype wire

//--- rtl/i2c_master_defs.svh
/*
 * Constants for the byte-transfer I2C master: sizes, bus timing, the ack bit index.
 * Assumes a 100 MHz system clock; included by the package and the modules.
 */
`ifndef I2C_MASTER_DEFS_SVH
`define I2C_MASTER_DEFS_SVH

`define I2C_CLK_PERIOD_NS 10
`define I2C_PIN_COUNT 8
`define I2C_PIN_SEL_W 3
`define I2C_PREFIX_SLOTS 5
`define I2C_ADDR_W 7
`define I2C_COUNT_W 8
`define I2C_TX_W 16
`define I2C_QLEN_W 10

// bit periods, ns, one per selectable rate
`define I2C_BIT_NS_350K 2857
`define I2C_BIT_NS_400K 2500
`define I2C_BIT_NS_100K 10000
`define I2C_BIT_NS_50K 20000

// a bit is four quarters; a least time, so round up
`define I2C_QUARTER_CYC(ns) (((ns) + 4 * `I2C_CLK_PERIOD_NS - 1) / (4 * `I2C_CLK_PERIOD_NS))

`define I2C_ACK_BIT 4'h8

`endif

//--- rtl/i2c_master_pkg.sv
/*
 * Types shared by the byte-transfer I2C master and its bit engine.
 * Assumes i2c_master_defs.svh for all sizes.
 */
`include "i2c_master_defs.svh"

package i2c_master_pkg;

    typedef enum logic [1:0] {
        RATE_350K = 2'h0,
        RATE_400K = 2'h1,
        RATE_100K = 2'h2,
        RATE_50K = 2'h3
    } bus_rate_select_t;

    typedef enum logic [1:0] {
        OP_START = 2'h0,
        OP_STOP = 2'h1,
        OP_BIT = 2'h2
    } bit_op_t;

    // gray codes along idle-start-addr-write-restart-read-stop-done
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_START = 3'h1,
        ST_ADDR = 3'h3,
        ST_WBYTE = 3'h2,
        ST_RESTART = 3'h6,
        ST_RBYTE = 3'h7,
        ST_STOP = 3'h5,
        ST_DONE = 3'h4
    } xfer_state_t;

    // skip set stands for a slot holding -1
    typedef struct packed {
        logic skip;
        logic [7:0] value;
    } prefix_byte_t;

    typedef struct packed {
        logic is_read;
        logic [`I2C_ADDR_W-1:0] target_address;
        logic [`I2C_PIN_SEL_W-1:0] sda_pin;
        logic [`I2C_PIN_SEL_W-1:0] scl_pin;
        logic [`I2C_COUNT_W-1:0] byte_count;
        prefix_byte_t [`I2C_PREFIX_SLOTS-1:0] prefix_byte;
    } xfer_cmd_t;

endpackage

//--- rtl/i2c_bit_engine.sv
/*
 * One I2C bus symbol (START, STOP or one data bit) in four equal quarters.
 * Assumes sda_in is already synchronised and go comes only while not busy.
 */
`timescale 1ns/100ps
`default_nettype none
`include "i2c_master_defs.svh"

module i2c_bit_engine
    import i2c_master_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic go,
    input wire bit_op_t op,
    input wire logic tx_bit,
    input wire logic [`I2C_QLEN_W-1:0] quarter_len,
    input wire logic sda_in,
    output logic done,
    output logic rx_bit,
    output logic scl_low,
    output logic sda_low
);

    logic busy_q;
    logic [1:0] phase_q;
    logic [`I2C_QLEN_W-1:0] cnt_q;
    bit_op_t op_q;
    logic val_q;
    logic quarter_end;

    assign quarter_end = (cnt_q == quarter_len - `I2C_QLEN_W'(1));

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            phase_q <= 2'h0;
            cnt_q <= '0;
            op_q <= OP_STOP;
            val_q <= 1'b1;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (go) begin
                busy_q <= 1'b1;
                phase_q <= 2'h0;
                cnt_q <= '0;
                op_q <= op;
                val_q <= tx_bit;
            end else if (busy_q) begin
                if (quarter_end) begin
                    cnt_q <= '0;
                    phase_q <= phase_q + 2'h1;
                    if (phase_q == 2'h3) begin
                        busy_q <= 1'b0;
                        done <= 1'b1;
                    end
                end else begin
                    cnt_q <= cnt_q + `I2C_QLEN_W'(1);
                end
            end
        end
    end

    // sample at the end of the high half of scl, just before it falls
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_bit <= 1'b1;
        end else if (busy_q && quarter_end && phase_q == 2'h2) begin
            rx_bit <= sda_in;
        end
    end

    // levels hold after the symbol so scl stays low between bits
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_low <= 1'b0;
            sda_low <= 1'b0;
        end else if (busy_q) begin
            case (op_q)
                OP_START: begin
                    // scl low first, so this also serves as a repeated start
                    scl_low <= (phase_q == 2'h0) || (phase_q == 2'h3);
                    sda_low <= phase_q[1];
                end
                OP_STOP: begin
                    scl_low <= (phase_q == 2'h0);
                    sda_low <= ~phase_q[1];
                end
                OP_BIT: begin
                    scl_low <= (phase_q == 2'h0) || (phase_q == 2'h3);
                    sda_low <= ~val_q;
                end
                default: begin
                    scl_low <= 1'b0;
                    sda_low <= 1'b0;
                end
            endcase
        end
    end

endmodule

`default_nettype wire

//--- tb/i2c_master_checker.sv
/* Port assertions for the byte-transfer I2C master, bound to its top module.
   Assumes one clk domain and an asynchronous active-high sys_rst. */
`timescale 1ns/100ps
`default_nettype none
`include "i2c_master_defs.svh"

module i2c_master_checker
    import i2c_master_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic cmd_valid,
    input wire logic cmd_ready,
    input wire xfer_cmd_t cmd,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic rx_valid,
    input wire logic done,
    input wire logic ack_result,
    input wire logic [`I2C_PIN_COUNT-1:0] pin_out,
    input wire logic [`I2C_PIN_COUNT-1:0] pin_oe_n
);
    logic rd_q;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // direction of the transaction in flight, so the streams can be tied to it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_q <= 1'h0;
        end else if (cmd_valid && cmd_ready) begin
            rd_q <= cmd.is_read;
        end
    end

    sequence s_take;
        cmd_valid && cmd_ready;
    endsequence

    sequence s_end;
        done ##1 (cmd_ready && (&pin_oe_n));
    endsequence

    AST_TAKE_BUSY: assert property (s_take |=> !cmd_ready [*8])
        else $error("ready stayed high after a command was taken");
    AST_TAKE_CLEAR: assert property (s_take |=> !ack_result)
        else $error("result not cleared when a command was taken");
    AST_ACK_HOLD: assert property (cmd_ready && !cmd_valid |=> $stable(ack_result))
        else $error("result changed while idle");
    AST_END_RELEASE: assert property (done |-> s_end)
        else $error("bus not released or not idle after done");
    AST_DONE_PULSE: assert property (done |=> !done [*8])
        else $error("done longer than one cycle");
    AST_RX_PULSE: assert property (rx_valid |=> !rx_valid [*8])
        else $error("received bytes closer than one byte time");
    AST_RX_READ: assert property (rx_valid |-> !cmd_ready && rd_q)
        else $error("received byte outside a read");
    AST_TX_WRITE: assert property (tx_ready |-> !cmd_ready && !rd_q)
        else $error("transmit stream asked outside a write");
    AST_TX_HOLD: assert property (tx_valid && tx_ready |=> !tx_ready [*8])
        else $error("transmit word asked again within one byte");
    AST_OPEN_DRAIN: assert property (pin_out == '0)
        else $error("pin driven high");
endmodule

bind i2c_master_byte_transfer i2c_master_checker i_i2c_master_checker (
    .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .done(done), .ack_result(ack_result), .pin_out(pin_out), .pin_oe_n(pin_oe_n)
);
`default_nettype wire

//--- tb/eeprom_model.sv
/* Behavioural I2C slave store: 256 bytes, pointer set by the first written byte.
   Assumes scl and sda are the resolved wire levels with pull-ups. */
`timescale 1ns/100ps
`default_nettype none

module eeprom_model #(
    parameter logic [6:0] ADDR = 7'h50
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_low
);
    logic [7:0] mem [256];
    logic [7:0] got [$];
    logic [7:0] sh, ob, ptr;
    logic act, rd, aph, ak, first;
    int bitn, starts, stops, macks, mnacks;

    initial begin
        sda_low = 1'h0;
        act = 1'h0;
        ptr = 8'h00;
        for (int i = 0; i < 256; i++) begin
            mem[i] = 8'(i) ^ 8'hA5;
        end
    end

    task automatic clear();
        got.delete();
        starts = 0;
        stops = 0;
        macks = 0;
        mnacks = 0;
    endtask

    always @(negedge sda) begin
        if (scl) begin
            act = 1'h1;
            aph = 1'h1;
            first = 1'h1;
            rd = 1'h0;
            ob = 8'hFF;
            // the scl fall that closes the start is not a data bit
            bitn = -1;
            starts++;
        end
    end

    always @(posedge sda) begin
        if (scl) begin
            act = 1'h0;
            stops++;
        end
    end

    always @(posedge scl) begin
        if (act && bitn < 8) begin
            sh = {sh[6:0], sda};
        end else if (act && rd && !aph) begin
            ak = !sda;
            if (ak) macks++;
            else mnacks++;
        end
    end

    // changes sda_low only on a scl fall, so it never fakes a start or stop
    always @(negedge scl) begin
        if (!act) begin
            sda_low = 1'h0;
        end else if (bitn < 7) begin
            bitn++;
            sda_low = !ob[7 - bitn];
        end else if (bitn == 7) begin
            bitn = 8;
            if (aph) rd = sh[0];
            sda_low = aph ? sh[7:1] == ADDR : !rd;
            if (!aph && !rd) begin
                got.push_back(sh);
                if (!first) mem[ptr] = sh;
                ptr = first ? sh : ptr + 8'h01;
                first = 1'h0;
            end
        end else begin
            bitn = 0;
            act = !aph || sh[7:1] == ADDR;
            // a master nack ends the read: the line is left to the pull-up
            if (act && rd && (aph || ak)) begin
                ob = mem[ptr];
                ptr = ptr + 8'h01;
            end else begin
                ob = 8'hFF;
            end
            sda_low = !ob[7];
            aph = 1'h0;
        end
    end
endmodule
`default_nettype wire

//--- tb/i2c_master_byte_transfer_tb.sv
/* Self-checking bench for the byte-transfer I2C master against a slave model.
   Assumes the slave answers at 7'h50 and all pins have pull-ups. */
`timescale 1ns/100ps
`default_nettype none
`include "i2c_master_defs.svh"

module i2c_master_byte_transfer_tb
    import i2c_master_pkg::*;
;
    localparam logic [8:0] SK = 9'h100;
    logic clk, sys_rst, cmd_valid, rate_set, tx_valid, cmd_ready, tx_ready;
    logic rx_valid, done, ack_result, slv_low, scl_w;
    xfer_cmd_t cmd;
    bus_rate_select_t bus_rate_select;
    logic [15:0] tx_data;
    logic [7:0] rx_data, pin_out, pin_oe_n, lvl;
    logic [2:0] sp, cp;
    logic [15:0] txq [$];
    logic [7:0] rxq [$];
    int err_total, n_tests, nrise;
    time t1, per;

    i2c_master_byte_transfer i_i2c_master_byte_transfer (
        .clk(clk), .sys_rst(sys_rst), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd(cmd), .rate_set(rate_set), .bus_rate_select(bus_rate_select),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data),
        .rx_valid(rx_valid), .done(done), .ack_result(ack_result), .pin_in(lvl),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n)
    );
    eeprom_model #(.ADDR(7'h50)) i_eeprom_model (
        .scl(scl_w), .sda(lvl[sp]), .sda_low(slv_low)
    );

    always_comb begin
        lvl = pin_oe_n | pin_out;
        lvl[sp] = lvl[sp] & !slv_low;
    end
    assign scl_w = lvl[cp];

    always @(posedge scl_w) begin
        nrise++;
        if (nrise == 1) t1 = $time;
        if (nrise == 2) per = ($time - t1) / 10;
    end

    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [63:0] s, input logic [63:0] e);
        n_tests++;
        if (s !== e) begin
            err_total++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic run(input logic rd, input logic [6:0] a, input logic [7:0] n,
                       input logic [44:0] pf);
        int w;
        logic took;
        w = 0;
        rxq.delete();
        nrise = 0;
        i_eeprom_model.clear();
        @(posedge clk);
        #1;
        cmd = {rd, a, sp, cp, n, pf};
        cmd_valid = 1'h1;
        @(posedge clk);
        #1;
        cmd_valid = 1'h0;
        while (done !== 1'h1 && w < 30000) begin
            tx_valid = txq.size() != 0;
            if (tx_valid) tx_data = txq[0];
            @(negedge clk);
            took = tx_valid && tx_ready === 1'h1;
            @(posedge clk);
            #1;
            if (rx_valid === 1'h1) rxq.push_back(rx_data);
            if (took) void'(txq.pop_front());
            w++;
        end
        check(done, 1'h1);
        txq.delete();
        tx_valid = 1'h0;
    endtask

    task automatic t_rates();
        int k [4] = '{350, 100, 50, 400};
        bus_rate_select_t r [4] = '{RATE_350K, RATE_100K, RATE_50K, RATE_400K};
        int q;
        for (int i = 0; i < 4; i++) begin
            if (i > 0) begin
                @(posedge clk);
                #1;
                bus_rate_select = r[i];
                rate_set = 1'h1;
                @(posedge clk);
                #1;
                rate_set = 1'h0;
            end
            q = (1000000 / k[i] + 39) / 40;
            run(1'h0, 7'h50, 8'h00, {5{SK}});
            check(per >= 4 * q && per <= 4 * q + 4, 1'h1);
            check(ack_result, 1'h1);
        end
        $display("rate test finished");
    endtask

    task automatic t_write();
        sp = 3'h3;
        cp = 3'h5;
        txq = '{16'hFF10, 16'hAB5A, 16'h1234};
        run(1'h0, 7'h50, 8'h03, {5{SK}});
        check(ack_result, 1'h1);
        check(i_eeprom_model.got.size(), 3);
        check({i_eeprom_model.got[0], i_eeprom_model.got[1]}, 16'h105A);
        check(i_eeprom_model.got[2], 8'h34);
        txq = '{16'h0001};
        run(1'h0, 7'h22, 8'h01, {5{SK}});
        check(ack_result, 1'h0);
        check(i_eeprom_model.got.size(), 0);
        $display("write test finished");
    endtask

    task automatic t_read();
        sp = 3'h6;
        cp = 3'h0;
        run(1'h1, 7'h50, 8'h02, {SK, SK, 9'h0C3, SK, 9'h020});
        check(rxq.size(), 2);
        check({rxq[0], rxq[1]}, {8'h21 ^ 8'hA5, 8'h22 ^ 8'hA5});
        check({i_eeprom_model.got[0], i_eeprom_model.got[1]}, 16'h20C3);
        check(i_eeprom_model.got.size(), 2);
        check({i_eeprom_model.starts, i_eeprom_model.stops}, {32'd2, 32'd1});
        check({i_eeprom_model.macks, i_eeprom_model.mnacks}, {32'd1, 32'd1});
        // a read on its own after the earlier write, as a slow slave needs
        run(1'h1, 7'h50, 8'h03, {SK, SK, SK, 9'h077, SK});
        check({rxq[0], rxq[2]}, {8'h23 ^ 8'hA5, 8'h25 ^ 8'hA5});
        check(i_eeprom_model.got.size(), 0);
        check(i_eeprom_model.starts, 1);
        check({i_eeprom_model.macks, i_eeprom_model.mnacks}, {32'd2, 32'd1});
        $display("read test finished");
    endtask

    initial begin
        sys_rst = 1'h1;
        cmd_valid = 1'h0;
        cmd = '0;
        rate_set = 1'h0;
        bus_rate_select = RATE_350K;
        tx_data = 16'h0000;
        tx_valid = 1'h0;
        sp = 3'h0;
        cp = 3'h1;
        err_total = 0;
        n_tests = 0;
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 1'h0;
        check({cmd_ready, tx_ready, rx_valid, done, ack_result, pin_oe_n}, 13'h10FF);
        t_rates();
        t_write();
        t_read();
        test_done();
    end

    // the tests need about 76k cycles; this allows about 95k
    initial begin
        #950000;
        err_total++;
        test_done();
    end
endmodule
`default_nettype wire
